// ==== pkg/dcr_defs.svh ====
// constants for the dual channel shadowed register map and its serial control port
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH
`define DCR_A_PORT_CFG   8'h00
`define DCR_A_DEV_ID     8'h01
`define DCR_A_GRADE_ID   8'h02
`define DCR_A_CHAN_SEL   8'h05
`define DCR_A_POWER      8'h08
`define DCR_A_CLOCK      8'h09
`define DCR_A_CLK_DIV    8'h0B
`define DCR_A_OPEN_13    8'h13
`define DCR_A_FORMAT     8'h14
`define DCR_A_SH_LO      8'h08
`define DCR_A_SH_HI      8'h20
`define DCR_A_SYNC       8'h3A
`define DCR_A_XFER       8'hFF
`define DCR_NSH          26
`define DCR_SYNC_IDX     5'h19
`define DCR_RST_PORT_CFG 8'h18
`define DCR_RST_CHAN_SEL 2'h3
`define DCR_RST_FORMAT   8'h05
`define DCR_RST_CLOCK    8'h01
`define DCR_RST_ZERO     8'h00
`define DCR_XFER_CMD     8'h01
`define DCR_PC_LSB_HI    6
`define DCR_PC_LSB_LO    1
`define DCR_PC_SRST_HI   5
`define DCR_PC_SRST_LO   2
`define DCR_XFER_BIT     0
`define DCR_IN_RW        15
`define DCR_IN_LEN_HI    14
`define DCR_IN_LEN_LO    13
`define DCR_LEN_STREAM   2'h3
`define DCR_INSTR_LAST   4'hF
`define DCR_BYTE_LAST    3'h7
`define DCR_FRAME_LAST   5'h17
`define DCR_DATA_FIRST   5'h10
`define DCR_MASK_PORT    8'h66
`define DCR_MASK_CHAN    8'h03
`define DCR_MASK_XFER    8'h01
`define DCR_MASK_POWER   8'h23
`define DCR_MASK_CLOCK   8'h01
`define DCR_MASK_CLKDIV  8'h3F
`define DCR_MASK_FULL    8'hFF
`define DCR_MASK_NONE    8'h00
`define DCR_SYS_PERIOD_NS  10
`define DCR_SCLK_PERIOD_NS 40
`define DCR_SCLK_HALF    4'((`DCR_SCLK_PERIOD_NS) / (2 * `DCR_SYS_PERIOD_NS))
`define DCR_H_CMD        4'h0
`define DCR_H_STAT       4'h4
`define DCR_CMD_RD       16
`define DCR_RESP_OKAY    2'h0
`define DCR_RESP_SLVERR  2'h2
`endif

// ==== pkg/dcr_pkg.sv ====
// types shared by both ends of the serial register port
package dcr_pkg;
    typedef enum logic [1:0] {DEV_INSTR, DEV_DATA, DEV_DONE} dcr_dev_state_t;
    typedef enum logic [0:0] {HST_IDLE, HST_SHIFT} dcr_host_state_t;
    typedef logic [7:0] dcr_byte_t;
endpackage

// ==== pkg/dcr_spi_if.sv ====
// three wire serial control link between host end and device end
`timescale 1ns/1ps
interface dcr_spi_if;
    logic sclk;
    logic port_select_low_n;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    wire  sdio_in;
    // pulled high when nobody drives
    assign sdio_in = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
    modport host (output sclk, output port_select_low_n, output host_sdio_o, output host_sdio_oe, input sdio_in);
    modport dev (input sclk, input port_select_low_n, input sdio_in, output dev_sdio_o, output dev_sdio_oe);
endinterface

// ==== hdl/dcr_dev_end.sv ====
// device end: serial slave with shadowed, channel indexed register map
`timescale 1ns/1ps
`include "dcr_defs.svh"
module dcr_dev_end #(
    parameter dcr_pkg::dcr_byte_t DEV_ID   = 8'hA5, // arbitrary value
    parameter dcr_pkg::dcr_byte_t GRADE_ID = 8'h20  // arbitrary value
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    dcr_spi_if.dev             spi,
    output dcr_pkg::dcr_byte_t act_power_a,
    output dcr_pkg::dcr_byte_t act_power_b,
    output dcr_pkg::dcr_byte_t act_format_a,
    output dcr_pkg::dcr_byte_t act_format_b,
    output dcr_pkg::dcr_byte_t act_clk_div,
    output dcr_pkg::dcr_byte_t act_sync,
    output logic               lsb_first
);
    import dcr_pkg::*;

    function automatic logic is_shadow(input dcr_byte_t a);
        is_shadow = (a >= `DCR_A_SH_LO && a <= `DCR_A_SH_HI) || a == `DCR_A_SYNC;
    endfunction

    function automatic logic [4:0] sh_idx(input dcr_byte_t a);
        sh_idx = (a == `DCR_A_SYNC) ? `DCR_SYNC_IDX : 5'(a - `DCR_A_SH_LO);
    endfunction

    // only these two carry per channel copies
    function automatic logic is_local(input dcr_byte_t a);
        is_local = (a == `DCR_A_POWER) || (a == `DCR_A_FORMAT);
    endfunction

    function automatic dcr_byte_t sh_default(input logic [4:0] i);
        if (i == sh_idx(`DCR_A_FORMAT))
            sh_default = `DCR_RST_FORMAT;
        else if (i == sh_idx(`DCR_A_CLOCK))
            sh_default = `DCR_RST_CLOCK;
        else
            sh_default = `DCR_RST_ZERO;
    endfunction

    dcr_dev_state_t state_ff;
    logic           sclk_q_ff;
    logic [3:0]     bit_ff;
    logic [15:0]    shift_ff;
    logic           rw_ff;
    logic [1:0]     len_ff;
    logic [1:0]     nbyte_ff;
    dcr_byte_t      addr_ff;
    dcr_byte_t      tx_ff;
    logic           sdo_ff;
    logic           oe_ff;
    logic           lsb_ff;
    logic [1:0]     chan_sel_ff;
    dcr_byte_t      sh_ff  [2][`DCR_NSH];
    dcr_byte_t      act_ff [2][`DCR_NSH];

    // sclk is sampled as a synchronous input, edges found against last sample
    wire        sel        = ~spi.port_select_low_n;
    wire        sclk_rise  = sel & spi.sclk & ~sclk_q_ff;
    wire        sclk_fall  = sel & ~spi.sclk & sclk_q_ff;
    wire        in_instr   = state_ff == DEV_INSTR;
    wire        in_data    = state_ff == DEV_DATA;
    wire [15:0] nxt_shift  = lsb_ff ? {spi.sdio_in, shift_ff[15:1]}
                                    : {shift_ff[14:0], spi.sdio_in};
    wire        instr_end  = sclk_rise & in_instr & (bit_ff == `DCR_INSTR_LAST);
    wire        byte_end   = sclk_rise & in_data & (bit_ff[2:0] == `DCR_BYTE_LAST);
    wire        nxt_rw     = nxt_shift[`DCR_IN_RW];
    wire [1:0]  nxt_len    = nxt_shift[`DCR_IN_LEN_HI:`DCR_IN_LEN_LO];
    wire [7:0]  wbyte      = lsb_ff ? nxt_shift[15:8] : nxt_shift[7:0];
    wire [7:0]  nxt_addr   = lsb_ff ? 8'(addr_ff + 8'h01) : 8'(addr_ff - 8'h01);
    wire        last_byte  = (len_ff != `DCR_LEN_STREAM) && (nbyte_ff == len_ff);
    wire        wr_stb     = byte_end & ~rw_ff;
    wire [7:0]  rd_addr    = in_instr ? nxt_shift[7:0] : nxt_addr;
    wire        rd_loc     = is_local(rd_addr);
    // both channels selected reads the first channel
    wire        rd_ch      = rd_loc & (chan_sel_ff == 2'h2);
    wire [4:0]  rd_i       = sh_idx(rd_addr);
    wire [7:0]  port_rd    = {1'b0, lsb_ff, 1'b0, 1'b1, 1'b1, 1'b0, lsb_ff, 1'b0};
    wire [7:0]  rd_data    = (rd_addr == `DCR_A_PORT_CFG) ? port_rd :
                             (rd_addr == `DCR_A_DEV_ID)   ? DEV_ID :
                             (rd_addr == `DCR_A_GRADE_ID) ? GRADE_ID :
                             (rd_addr == `DCR_A_CHAN_SEL) ? {6'h00, chan_sel_ff} :
                             is_shadow(rd_addr)           ? sh_ff[rd_ch][rd_i] :
                             `DCR_RST_ZERO; // transfer bit and unmapped read zero
    wire        wr_port    = wr_stb & (addr_ff == `DCR_A_PORT_CFG);
    wire        soft_rst   = wr_port & (wbyte[`DCR_PC_SRST_HI] | wbyte[`DCR_PC_SRST_LO]);
    wire        wr_chan    = wr_stb & (addr_ff == `DCR_A_CHAN_SEL);
    wire        wr_sh      = wr_stb & is_shadow(addr_ff);
    wire        wr_loc     = is_local(addr_ff);
    wire [4:0]  wr_i       = sh_idx(addr_ff);
    // transfer bit is never stored, so it reads back clear right after the update
    wire        xfer       = wr_stb & (addr_ff == `DCR_A_XFER) & wbyte[`DCR_XFER_BIT];

    assign spi.dev_sdio_o  = sdo_ff;
    assign spi.dev_sdio_oe = oe_ff;
    assign act_power_a     = act_ff[0][sh_idx(`DCR_A_POWER)];
    assign act_power_b     = act_ff[1][sh_idx(`DCR_A_POWER)];
    assign act_format_a    = act_ff[0][sh_idx(`DCR_A_FORMAT)];
    assign act_format_b    = act_ff[1][sh_idx(`DCR_A_FORMAT)];
    assign act_clk_div     = act_ff[0][sh_idx(`DCR_A_CLK_DIV)];
    assign act_sync        = act_ff[0][`DCR_SYNC_IDX];
    assign lsb_first       = lsb_ff;

    // frame sequencer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff  <= DEV_INSTR;
            sclk_q_ff <= 1'b0;
            bit_ff    <= 4'h0;
            shift_ff  <= 16'h0000;
            rw_ff     <= 1'b0;
            len_ff    <= 2'h0;
            nbyte_ff  <= 2'h0;
            addr_ff   <= 8'h00;
            tx_ff     <= 8'h00;
            sdo_ff    <= 1'b0;
            oe_ff     <= 1'b0;
        end
        else
        begin
            sclk_q_ff <= spi.sclk;
            if (!sel)
            begin
                // deselect ends the frame and frees the line
                state_ff <= DEV_INSTR;
                bit_ff   <= 4'h0;
                oe_ff    <= 1'b0;
            end
            else if (sclk_rise)
            begin
                shift_ff <= nxt_shift;
                bit_ff   <= 4'(bit_ff + 4'h1);
                if (instr_end)
                begin
                    state_ff <= DEV_DATA;
                    bit_ff   <= 4'h0;
                    rw_ff    <= nxt_rw;
                    len_ff   <= nxt_len;
                    nbyte_ff <= 2'h0;
                    addr_ff  <= nxt_shift[7:0];
                    tx_ff    <= rd_data;
                end
                else if (byte_end)
                begin
                    addr_ff  <= nxt_addr;
                    nbyte_ff <= 2'(nbyte_ff + 2'h1);
                    tx_ff    <= rd_data;
                    if (last_byte)
                        state_ff <= DEV_DONE;
                end
            end
            else if (sclk_fall && in_data && rw_ff)
            begin
                sdo_ff <= lsb_ff ? tx_ff[0] : tx_ff[7];
                tx_ff  <= lsb_ff ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
                oe_ff  <= 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lsb_ff      <= 1'b0;
            chan_sel_ff <= `DCR_RST_CHAN_SEL;
        end
        else if (soft_rst)
        begin
            lsb_ff      <= 1'b0;
            chan_sel_ff <= `DCR_RST_CHAN_SEL;
        end
        else
        begin
            if (wr_port)
                lsb_ff <= wbyte[`DCR_PC_LSB_HI] | wbyte[`DCR_PC_LSB_LO];
            if (wr_chan)
                chan_sel_ff <= wbyte[1:0];
        end
    end

    // shadow and active copies; channel select only steers local addresses
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int c = 0; c < 2; c++)
                for (int i = 0; i < `DCR_NSH; i++)
                begin
                    sh_ff[c][i]  <= sh_default(5'(i));
                    act_ff[c][i] <= sh_default(5'(i));
                end
        end
        else if (soft_rst)
        begin
            for (int c = 0; c < 2; c++)
                for (int i = 0; i < `DCR_NSH; i++)
                begin
                    sh_ff[c][i]  <= sh_default(5'(i));
                    act_ff[c][i] <= sh_default(5'(i));
                end
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                // globals land in both copies; reads and active outputs take them from the first copy
                if (wr_sh && (!wr_loc || chan_sel_ff[c]))
                    sh_ff[c][wr_i] <= wbyte;
                if (xfer)
                    for (int i = 0; i < `DCR_NSH; i++)
                        act_ff[c][i] <= sh_ff[c][i];
            end
        end
    end
endmodule

// ==== hdl/dcr_host_end.sv ====
// host end: axi4-lite command registers driving the three wire serial master
`timescale 1ns/1ps
`include "dcr_defs.svh"
module dcr_host_end (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    dcr_spi_if.host          spi
);
    import dcr_pkg::*;

    // bits a write may set; zero marks an address that must not be written
    function automatic dcr_byte_t wr_mask(input dcr_byte_t a);
        if (a == `DCR_A_PORT_CFG)
            wr_mask = `DCR_MASK_PORT;
        else if (a == `DCR_A_CHAN_SEL)
            wr_mask = `DCR_MASK_CHAN;
        else if (a == `DCR_A_XFER)
            wr_mask = `DCR_MASK_XFER;
        else if (a == `DCR_A_POWER)
            wr_mask = `DCR_MASK_POWER;
        else if (a == `DCR_A_CLOCK)
            wr_mask = `DCR_MASK_CLOCK;
        else if (a == `DCR_A_CLK_DIV)
            wr_mask = `DCR_MASK_CLKDIV;
        else if (a == `DCR_A_OPEN_13)
            wr_mask = `DCR_MASK_NONE;
        else if ((a >= `DCR_A_SH_LO && a <= `DCR_A_SH_HI) || a == `DCR_A_SYNC)
            wr_mask = `DCR_MASK_FULL;
        else
            wr_mask = `DCR_MASK_NONE;
    endfunction

    dcr_host_state_t state_ff;
    logic [3:0]  cnt_ff;
    logic [4:0]  bit_ff;
    logic [23:0] frame_ff;
    dcr_byte_t   rx_ff;
    dcr_byte_t   rdata_ff;
    logic        rd_ff, busy_ff, err_ff, sclk_ff, csn_ff, oe_ff;
    logic        aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [3:0]  awaddr_ff;
    logic [31:0] wdata_ff, rdata_bus_ff;
    logic [1:0]  bresp_ff, rresp_ff;

    wire        aw_take    = s_axi_awvalid & awready_ff;
    wire        w_take     = s_axi_wvalid & wready_ff;
    wire        do_wr      = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire        nxt_aw     = (aw_hold_ff | aw_take) & ~do_wr;
    wire        nxt_w      = (w_hold_ff | w_take) & ~do_wr;
    wire        nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);
    wire        ar_take    = s_axi_arvalid & arready_ff;
    wire        nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
    wire        cmd_hit    = do_wr & (awaddr_ff == `DCR_H_CMD);
    wire        cmd_rd     = wdata_ff[`DCR_CMD_RD];
    wire [7:0]  cmd_addr   = wdata_ff[15:8];
    wire [7:0]  cmd_mask   = wr_mask(cmd_addr);
    wire        cmd_bad    = cmd_rd ? (cmd_mask == `DCR_MASK_NONE && cmd_addr > `DCR_A_GRADE_ID)
                                    : (cmd_mask == `DCR_MASK_NONE);
    wire        start      = cmd_hit & ~busy_ff & ~cmd_bad;
    wire        tick       = (state_ff == HST_SHIFT) & (cnt_ff == `DCR_SCLK_HALF - 4'h1);
    wire        frame_end  = tick & sclk_ff & (bit_ff == `DCR_FRAME_LAST);
    wire [7:0]  nxt_rx     = {rx_ff[6:0], spi.sdio_in};
    wire [31:0] stat_word  = {16'h0000, rdata_ff, 6'h00, err_ff, busy_ff};

    assign spi.sclk              = sclk_ff;
    assign spi.port_select_low_n = csn_ff;
    assign spi.host_sdio_o       = frame_ff[23];
    assign spi.host_sdio_oe      = oe_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_bus_ff;
    assign s_axi_rresp   = rresp_ff;

    // axi4-lite slave, one write and one read at a time
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff} <= 4'h0;
            {awready_ff, wready_ff, arready_ff}           <= 3'h0;
            awaddr_ff    <= 4'h0;
            wdata_ff     <= 32'h0000_0000;
            rdata_bus_ff <= 32'h0000_0000;
            bresp_ff     <= `DCR_RESP_OKAY;
            rresp_ff     <= `DCR_RESP_OKAY;
        end
        else
        begin
            aw_hold_ff <= nxt_aw;
            w_hold_ff  <= nxt_w;
            bvalid_ff  <= nxt_bvalid;
            rvalid_ff  <= nxt_rvalid;
            awready_ff <= ~nxt_aw & ~nxt_bvalid;
            wready_ff  <= ~nxt_w & ~nxt_bvalid;
            arready_ff <= ~nxt_rvalid;
            if (aw_take)
                awaddr_ff <= s_axi_awaddr;
            if (w_take)
                wdata_ff <= s_axi_wdata;
            if (do_wr)
                bresp_ff <= start ? `DCR_RESP_OKAY : `DCR_RESP_SLVERR;
            if (ar_take)
            begin
                rdata_bus_ff <= (s_axi_araddr == `DCR_H_STAT) ? stat_word : 32'h0000_0000;
                rresp_ff     <= (s_axi_araddr == `DCR_H_STAT) ? `DCR_RESP_OKAY : `DCR_RESP_SLVERR;
            end
        end
    end

    // serial master: one byte frames, msb first, data set on sclk low
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= HST_IDLE;
            {cnt_ff, bit_ff} <= 9'h000;
            frame_ff <= 24'h00_0000;
            {rx_ff, rdata_ff} <= 16'h0000;
            {rd_ff, busy_ff, err_ff, sclk_ff, oe_ff} <= 5'h00;
            csn_ff <= 1'b1;
        end
        else
        begin
            if (cmd_hit && !busy_ff)
                err_ff <= cmd_bad;
            case (state_ff)
                HST_IDLE:
                begin
                    if (start)
                    begin
                        // one byte, read bit first; unused bits forced to zero
                        frame_ff <= {cmd_rd, 2'h0, 5'h00, cmd_addr,
                                     cmd_rd ? 8'h00 : (wdata_ff[7:0] & cmd_mask)};
                        rd_ff    <= cmd_rd;
                        busy_ff  <= 1'b1;
                        csn_ff   <= 1'b0;
                        oe_ff    <= 1'b1;
                        {cnt_ff, bit_ff} <= 9'h000;
                        state_ff <= HST_SHIFT;
                    end
                end
                HST_SHIFT:
                begin
                    cnt_ff <= tick ? 4'h0 : 4'(cnt_ff + 4'h1);
                    if (tick && !sclk_ff)
                        sclk_ff <= 1'b1;
                    else if (tick)
                    begin
                        // sample late in the high phase, device changes after the fall
                        sclk_ff <= 1'b0;
                        rx_ff   <= nxt_rx;
                        bit_ff  <= 5'(bit_ff + 5'h01);
                        frame_ff <= {frame_ff[22:0], 1'b0};
                        oe_ff   <= ~(rd_ff && (5'(bit_ff + 5'h01) >= `DCR_DATA_FIRST));
                        if (frame_end)
                        begin
                            csn_ff   <= 1'b1;
                            oe_ff    <= 1'b0;
                            busy_ff  <= 1'b0;
                            state_ff <= HST_IDLE;
                            if (rd_ff)
                                rdata_ff <= nxt_rx;
                        end
                    end
                end
                default:
                    state_ff <= HST_IDLE;
            endcase
        end
    end
endmodule

// ==== verif/dcr_asserts.sv ====
// concurrent checks on the three wire link between host end and device end
`timescale 1ns/1ps
module dcr_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic port_select_low_n,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_oe
);
    logic [4:0] rises_ff;
    logic       sclk_q_ff;
    logic [4:0] nxt_rises;
    // counts sclk rises inside one frame, cleared while deselected
    assign nxt_rises = port_select_low_n ? 5'h00 : rises_ff + {4'h0, sclk & ~sclk_q_ff};
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            {rises_ff, sclk_q_ff} <= 6'h00;
        else
            {rises_ff, sclk_q_ff} <= {nxt_rises, sclk};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_idle_sclk_low: assert property (port_select_low_n && $past(port_select_low_n) |-> !sclk)
        else $error("serial clock moved outside a frame");
    a_sclk_high_two: assert property ($rose(sclk) |-> sclk[*2] ##1 !sclk)
        else $error("serial clock high phase not two cycles");
    a_frame_bits: assert property ($rose(port_select_low_n) |-> rises_ff == 5'h18)
        else $error("frame did not carry 24 clock rises");
    a_frame_start: assert property ($fell(port_select_low_n) |-> host_sdio_oe && !sclk)
        else $error("frame opened without host driving or with clock high");
    a_one_driver: assert property (!(host_sdio_oe && dev_sdio_oe))
        else $error("both ends drive the data line");
    a_dev_quiet: assert property (port_select_low_n && $past(port_select_low_n) |-> !dev_sdio_oe)
        else $error("device drives while deselected");
    a_host_quiet: assert property (port_select_low_n && $past(port_select_low_n) |-> !host_sdio_oe)
        else $error("host drives while deselected");
    // readback may only start once the instruction phase is over
    a_turn_late: assert property (dev_sdio_oe && !port_select_low_n |-> rises_ff >= 5'h10)
        else $error("device drove during instruction phase");
    cover property ($fell(port_select_low_n));
    cover property ($rose(dev_sdio_oe));
    cover property ($rose(port_select_low_n));
endmodule

// ==== verif/tb.sv ====
// self-checking bench: axi4-lite commands through host end into device register map
`timescale 1ns/1ps
module tb;
    import dcr_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, lsb_first;
    logic [1:0]  bresp, rresp;
    dcr_byte_t   pwr_a, pwr_b, fmt_a, fmt_b, clk_div, sync_v, rb;
    int          errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    always #5 sys_clk = ~sys_clk;
    dcr_spi_if spi_link();
    dcr_host_end u_dcr_host_end (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .spi(spi_link.host));
    dcr_dev_end u_dcr_dev_end (.sys_clk(sys_clk), .rst_n(rst_n), .spi(spi_link.dev), .act_power_a(pwr_a),
        .act_power_b(pwr_b), .act_format_a(fmt_a), .act_format_b(fmt_b), .act_clk_div(clk_div),
        .act_sync(sync_v), .lsb_first(lsb_first));
    dcr_asserts u_dcr_asserts (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(spi_link.sclk),
        .port_select_low_n(spi_link.port_select_low_n), .host_sdio_oe(spi_link.host_sdio_oe),
        .dev_sdio_oe(spi_link.dev_sdio_oe));
    task automatic complete_run();
        if (errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // both channels offered together; each released at its own handshake
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // one serial frame, then poll status until the link is idle
    task automatic ser(input logic rw, input logic [7:0] a, input logic [7:0] d);
        logic [1:0]  r;
        logic [31:0] st;
        axi_wr(4'h0, {15'h0000, rw, a, d}, r);
        chk("command response", 32'h0, {30'h0, r});
        do axi_rd(4'h4, st, r);
        while (st[0] === 1'b1);
        chk("command error", 32'h0, {31'h0, st[1]});
        rb = st[15:8];
    endtask
    task automatic t_defaults();
        chk("format a", 32'h05, fmt_a);
        chk("format b", 32'h05, fmt_b);
        chk("power a", 32'h00, pwr_a);
        chk("sync", 32'h00, sync_v);
        chk("bit order", 32'h0, lsb_first);
        ser(1'b1, 8'h00, 8'h00);
        chk("port config", 32'h18, rb);
        ser(1'b1, 8'h05, 8'h00);
        chk("channel select", 32'h03, rb);
        ser(1'b1, 8'h09, 8'h00);
        chk("clock reg", 32'h01, rb);
        ser(1'b1, 8'h02, 8'h00);
        chk("grade id", 32'h20, rb);
    endtask
    task automatic t_shadow();
        ser(1'b0, 8'h14, 8'h01);
        chk("format held a", 32'h05, fmt_a);
        ser(1'b0, 8'h3A, 8'h07);
        chk("sync held", 32'h00, sync_v);
        ser(1'b0, 8'hFF, 8'h01);
        chk("format a moved", 32'h01, fmt_a);
        chk("format b moved", 32'h01, fmt_b);
        chk("sync moved", 32'h07, sync_v);
        ser(1'b1, 8'hFF, 8'h00);
        chk("transfer bit", 32'h00, rb);
    endtask
    task automatic t_channels();
        ser(1'b0, 8'h05, 8'h01);
        ser(1'b0, 8'h08, 8'h03);
        ser(1'b0, 8'h0B, 8'h05);
        ser(1'b0, 8'h05, 8'h02);
        ser(1'b0, 8'h08, 8'h20);
        ser(1'b0, 8'hFF, 8'h01);
        chk("power a", 32'h03, pwr_a);
        chk("power b", 32'h20, pwr_b);
        chk("clock divide", 32'h05, clk_div);
        ser(1'b1, 8'h08, 8'h00);
        chk("power b read", 32'h20, rb);
        ser(1'b0, 8'h05, 8'h03);
        ser(1'b1, 8'h08, 8'h00);
        chk("power both read", 32'h03, rb);
    endtask
    task automatic t_softrst();
        // mirrored bits let the msb first host still reach this register after the switch
        ser(1'b0, 8'h00, 8'h42);
        chk("lsb mode", 32'h1, lsb_first);
        ser(1'b0, 8'h00, 8'h24);
        chk("bit order back", 32'h0, lsb_first);
        chk("power a", 32'h00, pwr_a);
        chk("format b", 32'h05, fmt_b);
        chk("clock divide", 32'h00, clk_div);
        ser(1'b1, 8'h00, 8'h00);
        chk("port config", 32'h18, rb);
    endtask
    task automatic t_refuse();
        logic [1:0]  r;
        logic [31:0] d;
        axi_wr(4'h8, 32'h0, r);
        chk("bad write resp", 32'h2, {30'h0, r});
        axi_rd(4'h8, d, r);
        chk("bad read resp", 32'h2, {30'h0, r});
        chk("bad read data", 32'h0, d);
        axi_wr(4'h0, {16'h0000, 8'h13, 8'h00}, r);
        chk("open addr resp", 32'h2, {30'h0, r});
        axi_rd(4'h4, d, r);
        chk("open addr status", 32'h2, {30'h0, d[1:0]});
    endtask
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_defaults();
        t_shadow();
        t_channels();
        t_softrst();
        t_refuse();
        complete_run();
    end
    // about 20 frames of roughly 100 cycles each fit well below this
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            complete_run();
        end
    end
endmodule
